// *** rtl/eesl_params.svh ***
`ifndef EESL_PARAMS_SVH
`define EESL_PARAMS_SVH
// Notes on behaviour
// RULE1: Transaction begins only after start condition.
// RULE2: Stop condition ends the current command.
// RULE3: Write data committed only after stop.
// RULE4: Upper four address bits match type code.
// RULE5: 1k variant: one bit matches chip select.
// RULE6: 1k variant: two page bits pick 256-word range.
// RULE7: 2k page variant: three page bits.
// RULE8: 2k chip-select variant: three bits match inputs.
// RULE9: Last address bit: 0 write, 1 read.
// RULE10: Write-protect high inhibits all writes.
// RULE11: Receiver drives low acknowledge on ninth clock.
// RULE12: Acknowledge matching slave address.
// RULE13: Acknowledge every received write byte.
// RULE14: Read acknowledged by master continues next byte.
// RULE15: No acknowledge stops transmission until stop.
// RULE16: Byte write programs byte after stop.
// RULE17: Page write: sixteen bytes, low nibble increments.
// RULE18: After reads counter points one past last.
// RULE19: After writes counter stays at last written.
// RULE20: Nacked current read delivers exactly one byte.
// RULE21: Random read uses dummy-write address, may continue.
// RULE22: Sequential read spans array, ends nack stop.
// RULE23: Sample on SCL rise, change on fall.
// RULE24: Programming cycle completes within 10 ms.
// RULE25: Page write wraps within sixteen-byte page.
// RULE26: No address acknowledge while programming.

// Device-type code; the value is arbitrary.
`define EESL_TYPE_CODE 4'h5
// Variants: 0 = 1k, 1 = 2k page select, 2 = 2k chip select.
`define EESL_VAR_1K 2'h0
`define EESL_VAR_2K_PAGE 2'h1
`define EESL_VAR_2K_CS 2'h2
// Programming time in microseconds and derived cycle count.
`define EESL_PROG_TIME_US 10000
`define EESL_CLK_MHZ 100
`define EESL_PROG_CYCLES (`EESL_PROG_TIME_US * `EESL_CLK_MHZ)
// Page buffer depth and reset value of the address counter.
`define EESL_PAGE_BYTES 16
`define EESL_ADDR_RST 11'h000
`endif

// *** rtl/eesl_pkg.sv ***
package eesl_pkg;
   // Protocol phases of the slave.
   typedef enum logic [2:0] {
      EESL_IDLE,
      EESL_DEVADDR,
      EESL_WORDADDR,
      EESL_WDATA,
      EESL_RDATA,
      EESL_RACK,
      EESL_IGNORE
   } eesl_phase_t;
endpackage

// *** rtl/eesl_fifo.sv ***
`include "eesl_params.svh"
// ****************************************************************
// Small valid/ready FIFO that holds the page bytes until the stop.
// ****************************************************************
module eesl_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Filling side.
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Draining side.
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   // Discard all contents.
   input wire logic flush_i
);
   localparam int AW = $clog2(DEPTH);
   // Storage array.
   logic [WIDTH-1:0] mem_q [DEPTH];
   // Pointers with an extra wrap bit.
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;

   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem_q[rd_q[AW-1:0]];

   // Pointer update; a flush empties the buffer.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (flush_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         // A push into a full buffer is taken when a pop frees the slot in the same cycle.
         if (in_valid_i && (!full || out_ready_i)) begin
            wr_q <= wr_q + 1'b1;
         end
         if (out_ready_i && !empty) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   // Data storage has no reset.
   always_ff @(posedge mclk_i) begin
      if (in_valid_i && (!full || out_ready_i) && !flush_i) begin
         mem_q[wr_q[AW-1:0]] <= in_data_i;
      end
   end
endmodule

// *** rtl/eesl_slave.sv ***
`include "eesl_params.svh"
// ****************************************************************
// Two-wire serial memory slave front end with 2k byte array.
// ****************************************************************
module eesl_slave
   import eesl_pkg::*;
#(
   parameter int PROG_CYCLES = `EESL_PROG_CYCLES,
   parameter logic [1:0] VARIANT = `EESL_VAR_2K_PAGE
) (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Two-wire bus pins; sda is open drain.
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Straps.
   input wire logic chip_select_bit_2_i,
   input wire logic chip_select_bit_1_i,
   input wire logic chip_select_bit_0_i,
   input wire logic write_protect_i,
   // Status.
   output logic busy_o
);
   // ****************************************************************
   // State.
   // ****************************************************************
   typedef struct packed {
      logic [1:0] scl_s;          // SCL synchroniser.
      logic [1:0] sda_s;          // SDA synchroniser.
      logic scl_d1;               // Delayed synchronised SCL.
      logic sda_d1;               // Delayed synchronised SDA.
      eesl_phase_t phase;         // Protocol phase.
      logic [3:0] bitcnt;         // Bit within byte, 0..9.
      logic [7:0] shift;          // Shift register.
      logic [10:0] addr;          // Internal address counter.
      logic [2:0] page;           // Page bits from the slave address.
      logic wr_ok;                // Write allowed in this command.
      logic got_data;             // At least one data byte staged.
      logic sda_out;              // Drive SDA low when set.
      logic [31:0] prog_cnt;      // Programming timer.
      logic committing;           // Draining staged bytes into array.
   } eesl_state_t;

   eesl_state_t s_q;
   eesl_state_t s_d;
   // Memory array, written only from staged page data.
   logic [7:0] mem_q [2048];
   logic [7:0] rd_byte;
   // FIFO signals: entry is {address, data}.
   logic f_in_valid;
   logic f_in_ready;
   logic [18:0] f_in_data;
   logic f_out_valid;
   logic f_out_ready;
   logic [18:0] f_out_data;
   logic f_flush;
   // Edge events.
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;

   // Address match for the selected variant.
   function automatic logic addr_match(input logic [6:0] a, input logic [2:0] cs);
      logic ok;
      ok = (a[6:3] == `EESL_TYPE_CODE); // RULE4
      case (VARIANT)
         `EESL_VAR_1K: ok = ok && (a[2] == cs[2]); // RULE5
         `EESL_VAR_2K_CS: ok = ok && (a[2:0] == cs); // RULE8
         default: ok = ok; // RULE7
      endcase
      return ok;
   endfunction

   // Page bits from the slave address, per variant.
   function automatic logic [2:0] page_of(input logic [6:0] a);
      logic [2:0] p;
      case (VARIANT)
         `EESL_VAR_1K: p = {1'b0, a[1:0]}; // RULE6
         `EESL_VAR_2K_PAGE: p = a[2:0]; // RULE7
         default: p = 3'h0;
      endcase
      return p;
   endfunction

   // Edges of the twice-sampled pins.
   assign scl_rise = s_q.scl_s[1] && !s_q.scl_d1; // RULE23
   assign scl_fall = !s_q.scl_s[1] && s_q.scl_d1;
   assign start_ev = s_q.scl_s[1] && s_q.scl_d1 && s_q.sda_d1 && !s_q.sda_s[1]; // RULE1
   assign stop_ev = s_q.scl_s[1] && s_q.scl_d1 && !s_q.sda_d1 && s_q.sda_s[1]; // RULE2
   assign rd_byte = mem_q[s_q.addr];
   // A byte arriving at a full staging buffer pushes out the oldest entry.
   // That entry holds the same in-page slot, which the wrapped byte overwrites anyway.
   assign f_out_ready = s_q.committing || (f_in_valid && !f_in_ready); // RULE25

   eesl_fifo #(.WIDTH(19), .DEPTH(`EESL_PAGE_BYTES)) u_fifo (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(f_in_valid),
      .in_ready_o(f_in_ready),
      .in_data_i(f_in_data),
      .out_valid_o(f_out_valid),
      .out_ready_i(f_out_ready),
      .out_data_o(f_out_data),
      .flush_i(f_flush)
   );

   // ****************************************************************
   // Next-state logic.
   // ****************************************************************
   always_comb begin
      logic [10:0] waddr;
      waddr = 11'h000;
      s_d = s_q;
      f_in_valid = 1'b0;
      f_in_data = 19'h00000;
      f_flush = 1'b0;
      s_d.scl_s = {s_q.scl_s[0], scl_i};
      s_d.sda_s = {s_q.sda_s[0], sda_i};
      s_d.scl_d1 = s_q.scl_s[1];
      s_d.sda_d1 = s_q.sda_s[1];
      // Programming timer and drain of staged bytes.
      if (s_q.prog_cnt != 32'h0) begin
         s_d.prog_cnt = s_q.prog_cnt - 32'h1; // RULE24
      end
      if (s_q.committing && !f_out_valid) begin
         s_d.committing = 1'b0;
      end
      if (start_ev) begin
         // Start or repeated start; staged bytes of an unfinished write are lost.
         s_d.phase = EESL_DEVADDR;
         s_d.bitcnt = 4'h0;
         s_d.sda_out = 1'b0;
         if (!s_q.committing) begin
            f_flush = 1'b1; // RULE3
         end
         s_d.got_data = 1'b0;
      end else if (stop_ev) begin
         // Stop: commit staged bytes if any.
         if (s_q.got_data && s_q.wr_ok) begin
            s_d.committing = 1'b1; // RULE16
            s_d.prog_cnt = PROG_CYCLES; // RULE24
         end
         s_d.got_data = 1'b0;
         s_d.phase = EESL_IDLE; // RULE15
         s_d.sda_out = 1'b0;
      end else if (scl_rise) begin
         // Sample incoming bits on the rising SCL edge.
         if (s_q.phase != EESL_IDLE && s_q.phase != EESL_IGNORE) begin
            if (s_q.bitcnt < 4'h8) begin
               s_d.shift = {s_q.shift[6:0], s_q.sda_s[1]};
            end
            s_d.bitcnt = s_q.bitcnt + 4'h1;
         end
         if (s_q.phase == EESL_RDATA && s_q.bitcnt == 4'h8) begin
            // Ninth clock of a read byte: the master's answer.
            s_d.addr = s_q.addr + 11'h1; // RULE18
            s_d.phase = s_q.sda_s[1] ? EESL_IGNORE : EESL_RACK; // RULE14 RULE20
         end
      end else if (scl_fall) begin
         // Change outputs on the falling SCL edge.
         case (s_q.phase)
            EESL_DEVADDR: begin
               if (s_q.bitcnt == 4'h8) begin
                  if (addr_match(s_q.shift[7:1], {chip_select_bit_2_i, chip_select_bit_1_i,
                      chip_select_bit_0_i}) && s_q.prog_cnt == 32'h0) begin // RULE26
                     s_d.sda_out = 1'b1; // RULE12 RULE11
                     s_d.page = page_of(s_q.shift[7:1]);
                     if (s_q.shift[0]) begin
                        s_d.phase = EESL_RACK; // RULE9
                     end else begin
                        s_d.phase = EESL_WORDADDR;
                        s_d.wr_ok = !write_protect_i; // RULE10
                     end
                  end else begin
                     s_d.phase = EESL_IGNORE;
                  end
               end
            end
            EESL_WORDADDR, EESL_WDATA: begin
               if (s_q.bitcnt == 4'h8) begin
                  s_d.sda_out = 1'b1; // RULE13
                  if (s_q.phase == EESL_WORDADDR) begin
                     s_d.addr = {s_q.page, s_q.shift}; // RULE21
                     s_d.phase = EESL_WDATA;
                  end else begin
                     // Stage the byte; later bytes advance the low nibble inside the page.
                     f_in_valid = s_q.wr_ok && !write_protect_i; // RULE10
                     waddr = s_q.got_data ? {s_q.addr[10:4], s_q.addr[3:0] + 4'h1} :
                        s_q.addr; // RULE25
                     f_in_data = {waddr, s_q.shift}; // RULE17
                     s_d.got_data = s_q.got_data || f_in_valid;
                     // The counter stays on the last written slot.
                     if (f_in_valid) begin
                        s_d.addr = waddr; // RULE19
                     end
                  end
               end else if (s_q.bitcnt == 4'h9) begin
                  s_d.sda_out = 1'b0;
                  s_d.bitcnt = 4'h0;
               end
            end
            EESL_RACK: begin
               // After the acknowledge, drive the first bit of the next byte.
               s_d.sda_out = !rd_byte[7]; // RULE22
               s_d.shift = rd_byte;
               s_d.bitcnt = 4'h0;
               s_d.phase = EESL_RDATA;
            end
            EESL_RDATA: begin
               if (s_q.bitcnt < 4'h8) begin
                  // Each rising edge shifts left, so the next bit is always on top.
                  s_d.sda_out = !s_q.shift[7];
               end else begin
                  s_d.sda_out = 1'b0; // RULE11
               end
            end
            default: begin
               s_d.sda_out = 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // State register.
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d1: 1'b1, sda_d1: 1'b1, phase: EESL_IDLE,
                  bitcnt: 4'h0, shift: 8'h00, addr: `EESL_ADDR_RST, page: 3'h0, wr_ok: 1'b0,
                  got_data: 1'b0, sda_out: 1'b0, prog_cnt: 32'h0, committing: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Array programming from staged bytes; address counter stays put.
   // ****************************************************************
   always_ff @(posedge mclk_i) begin
      if (s_q.committing && f_out_valid) begin
         mem_q[f_out_data[18:8]] <= f_out_data[7:0]; // RULE3 RULE19
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = s_q.sda_out;
   assign busy_o = (s_q.prog_cnt != 32'h0);
endmodule

// *** verification/eesl_slave_props.sv ***
// ***
// Protocol checker at the pins of the memory slave.
// ***
module eesl_slave_props #(
   parameter int PROG_CYCLES = 200,
   parameter logic [1:0] VARIANT = 2'h1
) (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Pins and status.
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic busy_o
);
   logic scl_q, sda_q, frame_q; // Last pin levels and an open frame.
   logic [3:0] stop_age_q; // Cycles since a stop, saturating.
   logic [1:0] rst_age_q; // Cycles since reset, saturating.
   int busy_len_q; // Length of the busy run so far.
   wire start_w = scl_i && scl_q && sda_q && !sda_i;
   wire stop_w = scl_i && scl_q && !sda_q && sda_i;
   // Follows start, stop and busy as seen at the pins.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {scl_q, sda_q, frame_q, stop_age_q, rst_age_q} <= {3'b110, 4'hf, 2'h0};
         busy_len_q <= 0;
      end else begin
         {scl_q, sda_q} <= {scl_i, sda_i};
         frame_q <= start_w || (frame_q && !stop_w);
         stop_age_q <= stop_w ? 4'h0 : stop_age_q + {3'h0, stop_age_q != 4'hf};
         rst_age_q <= rst_age_q + {1'b0, rst_age_q != 2'h3};
         busy_len_q <= busy_o ? busy_len_q + 1 : 0;
      end
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   AST_OD_LOW: assert property (sda_oe_o |-> !sda_o)
      else $error("data pin driven high");
   AST_OE_SCL_LOW: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 2))
      else $error("data drive changed outside clock low");
   AST_DRIVE_IN_FRAME: assert property (sda_oe_o |-> frame_q)
      else $error("data driven outside a frame");
   AST_QUIET_RESET: assert property (rst_age_q != 2'h3 |-> !sda_oe_o && !busy_o)
      else $error("activity right after reset");
   AST_BUSY_AFTER_STOP: assert property ($rose(busy_o) |-> stop_age_q < 4'h9)
      else $error("programming began without a stop");
   AST_BUSY_LEN: assert property ($fell(busy_o) |-> busy_len_q == PROG_CYCLES)
      else $error("programming time wrong");
   AST_NO_ACK_BUSY: assert property (busy_o |-> !sda_oe_o)
      else $error("acknowledge while programming");
   AST_STOP_QUIET: assert property (stop_w |-> (!sda_oe_o) [*4])
      else $error("data driven after stop");
   // Main scenarios reached.
   cover property ($rose(busy_o));
   cover property (frame_q && $rose(sda_oe_o));
   cover property (stop_w);
endmodule
bind eesl_slave eesl_slave_props #(.PROG_CYCLES(PROG_CYCLES), .VARIANT(VARIANT)) u_props (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .busy_o(busy_o));

// *** verification/eesl_master.sv ***
// ***
// Bus master model; the bus clock rests high between frames.
// ***
module eesl_master (
   // Clock.
   input wire logic mclk_i,
   // Pins; sda_low_o high pulls the data line low.
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus: clock high, data released.
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // Sets both pins on an edge, then lets n edges pass.
   task automatic step(input logic c, input logic l, input int n);
      scl_o <= c;
      sda_low_o <= l;
      repeat (n) @(posedge mclk_i);
   endtask
   // Data falls while the clock is high.
   task automatic start_c();
      step(1'b0, 1'b0, 2);
      step(1'b1, 1'b0, 4);
      step(1'b1, 1'b1, 4);
      step(1'b0, 1'b1, 2);
   endtask
   // Data rises while the clock is high.
   task automatic stop_c();
      step(1'b0, 1'b1, 2);
      step(1'b1, 1'b1, 4);
      step(1'b1, 1'b0, 4);
   endtask
   // Data set in the low half, sampled late in the high half.
   task automatic bit_x(input logic b, output logic s);
      step(1'b0, !b, 2);
      step(1'b1, !b, 3);
      s = sda_i;
      step(1'b1, !b, 1);
      step(1'b0, !b, 2);
   endtask
   // Eight bits MSB first, then the acknowledge bit.
   task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(a, k);
   endtask
endmodule

// *** verification/eesl_slave_bench.sv ***
`include "eesl_params.svh"
// ***
// Self-checking bench for the memory slave.
// ***
module eesl_slave_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PROG = 200; // Shortened programming time.
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic wp = 1'b0;
   logic [2:0] cs = 3'h5;
   wire scl, m_low, sda_o, sda_oe, busy;
   wire sda_line = !(m_low || (sda_oe && !sda_o)); // Pulled up.
   int mismatches = 0;
   int cmp_count = 0;
   logic [7:0] q, exp_b [16];
   logic ak;
   always #5 mclk = ~mclk;
   eesl_master u_master (.mclk_i(mclk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(m_low));
   eesl_slave #(.PROG_CYCLES(PROG), .VARIANT(`EESL_VAR_2K_PAGE)) dut (
      .mclk_i(mclk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
      .sda_oe_o(sda_oe), .chip_select_bit_2_i(cs[2]), .chip_select_bit_1_i(cs[1]),
      .chip_select_bit_0_i(cs[0]), .write_protect_i(wp), .busy_o(busy));
   // Compares one value and counts it.
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("Counts: %0d mismatches in %0d comparisons", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Bus helpers; an acknowledge reads 0.
   task automatic put(input logic [7:0] d, input logic e);
      u_master.byte_x(d, 1'b1, q, ak);
      chk("ack", {7'h0, e}, {7'h0, ak});
   endtask
   task automatic addr(input logic [2:0] p, input logic rw, input logic e);
      u_master.start_c();
      put({`EESL_TYPE_CODE, p, rw}, e);
   endtask
   task automatic get(input logic ma);
      u_master.byte_x(8'hff, ma, q, ak);
   endtask
   task automatic wr_set(input logic [2:0] p, input logic [7:0] w);
      addr(p, 1'b0, 1'b0);
      put(w, 1'b0);
   endtask
   task automatic rd_at(input logic [2:0] p, input logic [7:0] w, input logic [7:0] e);
      wr_set(p, w);
      addr(p, 1'b1, 1'b0);
      get(1'b1);
      chk("random read", e, q);
      u_master.stop_c();
   endtask
   task automatic wait_ready();
      repeat (8) @(posedge mclk);
      for (int i = 0; i < 1000 && busy !== 1'b0; i++) begin
         @(posedge mclk);
      end
      chk("busy end", 8'h0, {7'h0, busy});
   endtask
   // Byte write, refused address while busy, read back.
   task automatic t_byte_write();
      wr_set(3'h3, 8'h2a);
      put(8'hc3, 1'b0);
      u_master.stop_c();
      repeat (8) @(posedge mclk);
      chk("busy", 8'h1, {7'h0, busy});
      addr(3'h3, 1'b0, 1'b1);
      u_master.stop_c();
      wait_ready();
      addr(3'h3, 1'b1, 1'b0);
      get(1'b1);
      chk("current after write", 8'hc3, q);
      u_master.stop_c();
      rd_at(3'h3, 8'h2a, 8'hc3);
      $display("test byte_write done");
   endtask
   // Write cut by a repeated start, then a protected write.
   task automatic t_abort();
      wr_set(3'h0, 8'h40);
      put(8'h77, 1'b0);
      u_master.stop_c();
      wait_ready();
      wr_set(3'h0, 8'h40);
      put(8'h55, 1'b0);
      rd_at(3'h0, 8'h40, 8'h77);
      chk("busy", 8'h0, {7'h0, busy});
      wp <= 1'b1;
      wr_set(3'h0, 8'h40);
      put(8'h99, 1'b0);
      u_master.stop_c();
      wait_ready();
      wp <= 1'b0;
      rd_at(3'h0, 8'h40, 8'h77);
      $display("test abort_protect done");
   endtask
   // Seventeen bytes wrap in the page; sequential and current read.
   task automatic t_page();
      wr_set(3'h1, 8'h5e);
      for (int i = 0; i < 17; i++) begin
         put(8'h20 + i[7:0], 1'b0);
         exp_b[(14 + i) % 16] = 8'h20 + i[7:0];
      end
      u_master.stop_c();
      wait_ready();
      wr_set(3'h1, 8'h50);
      addr(3'h1, 1'b1, 1'b0);
      for (int j = 0; j < 15; j++) begin
         get(j == 14);
         chk("sequential read", exp_b[j], q);
      end
      u_master.stop_c();
      addr(3'h1, 1'b1, 1'b0);
      get(1'b1);
      chk("current read", exp_b[15], q);
      u_master.stop_c();
      $display("test page done");
   endtask
   // Foreign type code, and clocking on after a missing acknowledge.
   task automatic t_refuse();
      u_master.start_c();
      put({~`EESL_TYPE_CODE, 3'h0, 1'b0}, 1'b1);
      get(1'b1);
      chk("unselected line", 8'hff, q);
      u_master.stop_c();
      addr(3'h1, 1'b1, 1'b0);
      get(1'b1);
      get(1'b1);
      chk("after nack", 8'hff, q);
      u_master.stop_c();
      $display("test refuse done");
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_byte_write();
      t_abort();
      t_page();
      t_refuse();
      give_verdict();
   end
   initial begin
      #600000;
      mismatches++;
      $display("test watchdog expired");
      give_verdict();
   end
endmodule
